// ### verilog/pcpc_top.sv
// Purpose: clock path control word and the logic it steers
// Assumes: clock inputs are slow against CLK and sampled
// Notes: boost currents reported in 50 uA units
`timescale 1ns/1ns
`include "pcpc_consts.svh"
module pcpc_top
  import pcpc_pkg::*;
(
  // clock and reset
  input  wire logic                    CLK,
  input  wire logic                    NRST,
  // control word port
  input  wire logic                    WORD_WR,
  input  wire logic [4:0]              WORD_BE,
  input  wire logic [`PCPC_WORD_W-1:0] WORD_WDATA,
  output logic      [`PCPC_WORD_W-1:0] WORD_RDATA,
  output logic                         WORD_ERR,
  // clock pins
  input  wire logic                    RF_CLOCK_INPUT,
  input  wire logic                    FEEDBACK_CLOCK_INPUT,
  input  wire logic                    REFERENCE_INPUT,
  // clock path outputs
  output logic                         SYNTH_SYSTEM_CLOCK,
  output logic                         RF_DIV_ON,
  output logic                         DRIVER_ON,
  output logic                         DRIVER_OUT,
  output logic      [`PCPC_BW-1:0]     RISE_BOOST,
  output logic      [`PCPC_BW-1:0]     FALL_BOOST,
  // charge pump
  output logic                         PUMP_UP,
  output logic                         PUMP_DN,
  output logic                         PUMP_CORE_ON,
  output logic      [3:0]              PUMP_SCALE,
  // shared sync/indicator pin
  input  wire logic                    STATUS_PIN_I,
  output logic                         STATUS_PIN_O,
  output logic                         STATUS_PIN_OE,
  output logic                         SYNC_IN_Q,
  output logic                         LOCKED
);
  // ==========================================================
  // helpers
  function automatic logic [`PCPC_BW-1:0] boost_sum(
    input logic [2:0]          bits,
    input logic [`PCPC_BW-1:0] w2,
    input logic [`PCPC_BW-1:0] w1,
    input logic [`PCPC_BW-1:0] w0,
    input logic [`PCPC_BW-1:0] def,
    input logic                dis
  );
    logic [`PCPC_BW-1:0] s;
    s = def;
    if (bits[2]) s = s + w2;
    if (bits[1]) s = s + w1;
    if (bits[0]) s = s + w0;
    return dis ? '0 : s;
  endfunction

  function automatic logic [4:0] plus_one(input logic [3:0] f);
    return {1'b0, f} + 5'h01;
  endfunction

  // ==========================================================
  // control word
  logic [`PCPC_WORD_W-1:0] word_reg, word_next;
  logic                    err_reg, err_next;

  always_comb begin
    word_next = word_reg;
    err_next  = 1'b0;
    if (WORD_WR) begin
      if (WORD_BE == `PCPC_BE_ALL) begin
        word_next = WORD_WDATA;
      end else begin
        err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      word_reg <= `PCPC_WORD_RST;
      err_reg  <= 1'b0;
    end else begin
      word_reg <= word_next;
      err_reg  <= err_next;
    end
  end

  assign WORD_RDATA = word_reg;
  assign WORD_ERR   = err_reg;

  logic       rf_pd, drv_pd, bst_dis, sys_src, ld_en, ld_mode;
  logic       cp_pol, cp_full, cp_quick;
  pcpc_drv_t  drv_sel;
  logic [4:0] r_ratio;
  assign rf_pd    = word_reg[`PCPC_RF_PD];
  assign drv_pd   = word_reg[`PCPC_DRV_PD];
  assign bst_dis  = word_reg[`PCPC_BOOST_DIS];
  assign sys_src  = word_reg[`PCPC_SYS_SRC];
  assign ld_en    = word_reg[`PCPC_LD_EN];
  assign ld_mode  = word_reg[`PCPC_LD_MODE];
  assign cp_pol   = word_reg[`PCPC_CP_POL];
  assign cp_full  = word_reg[`PCPC_CP_FULL_PD];
  assign cp_quick = word_reg[`PCPC_CP_QUICK_PD];
  assign drv_sel  = pcpc_drv_t'(word_reg[`PCPC_DRV_SEL_HI:`PCPC_DRV_SEL_LO]);
  // 2^field gives 1,2,4,8
  assign r_ratio  = 5'h01 << word_reg[`PCPC_RF_RAT_HI:`PCPC_RF_RAT_LO];

  // ==========================================================
  // pin synchronisers
  logic [3:0] s1_reg, s2_reg, s3_reg;
  logic       rf_s, fb_s, ref_s, pin_s;
  logic       rf_rise, fb_rise, ref_rise;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 4'h0;
    end else begin
      s1_reg <= {STATUS_PIN_I, REFERENCE_INPUT, FEEDBACK_CLOCK_INPUT, RF_CLOCK_INPUT};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign rf_s     = s2_reg[0];
  assign fb_s     = s2_reg[1];
  assign ref_s    = s2_reg[2];
  assign pin_s    = s2_reg[3];
  assign rf_rise  = s2_reg[0] & ~s3_reg[0];
  assign fb_rise  = s2_reg[1] & ~s3_reg[1];
  assign ref_rise = s2_reg[2] & ~s3_reg[2];

  // ==========================================================
  // dividers
  logic rf_div_lvl, fb_tick, ref_tick;

  pcpc_div #(.W(5)) u_rdiv (
    .clk       (CLK),
    .nrst      (NRST),
    .en        (~rf_pd),
    .in_level  (rf_s),
    .in_rise   (rf_rise),
    .ratio     (r_ratio),
    .out_tick  (),
    .out_level (rf_div_lvl)
  );

  pcpc_div #(.W(5)) u_ndiv (
    .clk       (CLK),
    .nrst      (NRST),
    .en        (1'b1),
    .in_level  (fb_s),
    .in_rise   (fb_rise),
    .ratio     (plus_one(word_reg[`PCPC_N_HI:`PCPC_N_LO])),
    .out_tick  (fb_tick),
    .out_level ()
  );

  pcpc_div #(.W(5)) u_mdiv (
    .clk       (CLK),
    .nrst      (NRST),
    .en        (1'b1),
    .in_level  (ref_s),
    .in_rise   (ref_rise),
    .ratio     (plus_one(word_reg[`PCPC_M_HI:`PCPC_M_LO])),
    .out_tick  (ref_tick),
    .out_level ()
  );

  // ==========================================================
  // phase detector and lock detect
  pcpc_pfd_t  pfd_reg, pfd_next;
  logic [5:0] err_cnt_reg, err_cnt_next;
  logic [4:0] good_reg, good_next;
  logic       lag_reg, lag_next;
  logic       locked_reg, locked_next;
  logic       done;
  logic       ok;

  always_comb begin
    pfd_next     = pfd_reg;
    err_cnt_next = err_cnt_reg;
    good_next    = good_reg;
    lag_next     = lag_reg;
    locked_next  = locked_reg;
    done         = 1'b0;
    ok           = (err_cnt_reg <= `PCPC_LOCK_WIN);
    case (pfd_reg)
      PCPC_PFD_IDLE: begin
        err_cnt_next = 6'h00;
        if (ref_tick && !fb_tick) pfd_next = PCPC_PFD_UP;
        if (fb_tick && !ref_tick) pfd_next = PCPC_PFD_DN;
        if (ref_tick && fb_tick) begin
          done = 1'b1;
          ok   = 1'b1;
        end
      end
      PCPC_PFD_UP: begin
        if (fb_tick) begin
          pfd_next = PCPC_PFD_IDLE;
          lag_next = 1'b1;
          done     = 1'b1;
        end
      end
      PCPC_PFD_DN: begin
        if (ref_tick) begin
          pfd_next = PCPC_PFD_IDLE;
          lag_next = 1'b0;
          done     = 1'b1;
        end
      end
      default: pfd_next = PCPC_PFD_IDLE;
    endcase
    if (pfd_reg != PCPC_PFD_IDLE && err_cnt_reg != 6'h3f) begin
      err_cnt_next = err_cnt_reg + 6'h01;
    end
    if (done) begin
      if (!ok) begin
        good_next   = 5'h00;
        locked_next = 1'b0;
      end else if (good_reg == `PCPC_LOCK_CNT - 5'h01) begin
        locked_next = 1'b1;
      end else begin
        good_next = good_reg + 5'h01;
      end
    end
    if (cp_full) begin
      pfd_next    = PCPC_PFD_IDLE;
      good_next   = 5'h00;
      locked_next = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pfd_reg     <= PCPC_PFD_IDLE;
      err_cnt_reg <= 6'h00;
      good_reg    <= 5'h00;
      lag_reg     <= 1'b0;
      locked_reg  <= 1'b0;
    end else begin
      pfd_reg     <= pfd_next;
      err_cnt_reg <= err_cnt_next;
      good_reg    <= good_next;
      lag_reg     <= lag_next;
      locked_reg  <= locked_next;
    end
  end

  // ==========================================================
  // registered outputs
  logic       sys_next, div_on_next, drv_on_next, drv_next;
  logic       up_next, dn_next, core_next, pin_o_next, pin_oe_next, sync_next;
  logic       up_raw, dn_raw;
  logic [`PCPC_BW-1:0] rise_next, fall_next;
  logic [3:0] scale_next;
  logic       sys_reg, div_on_reg, drv_on_reg, drv_reg;
  logic       up_reg, dn_reg, core_reg, pin_o_reg, pin_oe_reg, sync_reg;
  logic [`PCPC_BW-1:0] rise_reg, fall_reg;
  logic [3:0] scale_reg;

  always_comb begin
    div_on_next = ~rf_pd;
    sys_next    = (rf_pd || sys_src) ? rf_s : rf_div_lvl;
    drv_on_next = ~drv_pd;
    case (drv_sel)
      PCPC_DRV_NONE: drv_next = 1'b0;
      PCPC_DRV_FB:   drv_next = fb_s;
      PCPC_DRV_DOUT: drv_next = rf_div_lvl;
      PCPC_DRV_DIN:  drv_next = rf_s;
      default:       drv_next = 1'b0;
    endcase
    if (drv_pd) drv_next = 1'b0;
    rise_next = boost_sum(word_reg[`PCPC_RISE_HI:`PCPC_RISE_LO], `PCPC_RISE_W2,
                          `PCPC_RISE_W1, `PCPC_RISE_W0, `PCPC_RISE_DEF,
                          bst_dis);
    fall_next = boost_sum(word_reg[`PCPC_FALL_HI:`PCPC_FALL_LO], `PCPC_FALL_W2,
                          `PCPC_FALL_W1, `PCPC_FALL_W0, `PCPC_FALL_DEF,
                          bst_dis);
    up_raw      = (pfd_reg == PCPC_PFD_UP);
    dn_raw      = (pfd_reg == PCPC_PFD_DN);
    up_next     = (cp_pol ? dn_raw : up_raw) & ~cp_full & ~cp_quick;
    dn_next     = (cp_pol ? up_raw : dn_raw) & ~cp_full & ~cp_quick;
    core_next   = ~cp_full;
    scale_next  = {1'b0, word_reg[`PCPC_CP_SCL_HI:`PCPC_CP_SCL_LO]} + 4'h1;
    pin_oe_next = ld_en;
    pin_o_next  = ld_en & (ld_mode ? lag_reg : ~locked_reg);
    sync_next   = ld_en ? 1'b0 : pin_s;
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sys_reg    <= 1'b0;
      div_on_reg <= 1'b0;
      drv_on_reg <= 1'b0;
      drv_reg    <= 1'b0;
      rise_reg   <= '0;
      fall_reg   <= '0;
      up_reg     <= 1'b0;
      dn_reg     <= 1'b0;
      core_reg   <= 1'b0;
      scale_reg  <= 4'h0;
      pin_o_reg  <= 1'b0;
      pin_oe_reg <= 1'b0;
      sync_reg   <= 1'b0;
    end else begin
      sys_reg    <= sys_next;
      div_on_reg <= div_on_next;
      drv_on_reg <= drv_on_next;
      drv_reg    <= drv_next;
      rise_reg   <= rise_next;
      fall_reg   <= fall_next;
      up_reg     <= up_next;
      dn_reg     <= dn_next;
      core_reg   <= core_next;
      scale_reg  <= scale_next;
      pin_o_reg  <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
      sync_reg   <= sync_next;
    end
  end

  assign SYNTH_SYSTEM_CLOCK = sys_reg;
  assign RF_DIV_ON          = div_on_reg;
  assign DRIVER_ON          = drv_on_reg;
  assign DRIVER_OUT         = drv_reg;
  assign RISE_BOOST         = rise_reg;
  assign FALL_BOOST         = fall_reg;
  assign PUMP_UP            = up_reg;
  assign PUMP_DN            = dn_reg;
  assign PUMP_CORE_ON       = core_reg;
  assign PUMP_SCALE         = scale_reg;
  assign STATUS_PIN_O       = pin_o_reg;
  assign STATUS_PIN_OE      = pin_oe_reg;
  assign SYNC_IN_Q          = sync_reg;
  assign LOCKED             = locked_reg;

  // ==========================================================
  // checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_partial_wr;
    WORD_WR && (WORD_BE != `PCPC_BE_ALL);
  endsequence

  sequence s_pin_idle;
    !STATUS_PIN_OE && !STATUS_PIN_O;
  endsequence

  a_partial_kept: assert property (s_partial_wr |=> $stable(word_reg) && WORD_ERR)
    else $error("partial word write changed the word");
  a_pin_disabled: assert property (!ld_en ##1 !ld_en |=> s_pin_idle)
    else $error("indicator pin driven while disabled");
  a_lock_status: assert property (ld_en && !ld_mode |=> STATUS_PIN_O == !$past(locked_reg))
    else $error("status pin does not show lock state");
  a_lag_status: assert property (ld_en && ld_mode |=> STATUS_PIN_O == $past(lag_reg))
    else $error("status pin does not show lead/lag");
  a_rf_bypass: assert property (rf_pd |=> !RF_DIV_ON && SYNTH_SYSTEM_CLOCK == $past(rf_s))
    else $error("rf bypass path wrong");
  a_driver_off: assert property (drv_pd |=> !DRIVER_ON && !DRIVER_OUT)
    else $error("driver active while powered down");
  a_boost_off: assert property (bst_dis |=> RISE_BOOST == '0 && FALL_BOOST == '0)
    else $error("boost present while disabled");
  a_boost_def: assert property (!bst_dis && word_reg[31:26] == 6'h00
                                |=> RISE_BOOST == 9'h098 && FALL_BOOST == 9'h051)
    else $error("default boost wrong");
  a_pump_quiet: assert property ((cp_full || cp_quick) |=> !PUMP_UP && !PUMP_DN)
    else $error("pump output active while powered down");
  a_pump_scale: assert property (1'b1 |=> PUMP_SCALE == $past(word_reg[2:0]) + 4'h1)
    else $error("pump scale wrong");
endmodule

// ### verilog/pcpc_consts.svh
// Purpose: constants for the clock path control word logic
// Assumes: 100 MHz CLK; boost currents in 50 uA units
// Notes: none
// Function
// - lock-detect enable bit 25 drives the indicator pin as lock output
// - mode 0: pin shows 0 locked, 1 unlocked
// - mode 1: pin shows 1 feedback lags reference, 0 leads
// - rf divider power-down stops divider, routes rf input to system clock
// - ratio field 11/10/01/00 gives R of 8/4/2/1, 1 passes input level through
// - driver power-down resets to 1 (off), writing 0 powers up
// - driver source 00 none, 01 feedback, 10 divider out, 11 divider in
// - bits 31..29 add rising boost 7.6, 3.8, 1.9 mA
// - bits 28..26 add falling boost 5.4, 2.7, 1.35 mA
// - boost not disabled adds default 7.6 rising and 4.05 falling
// - boost-disable bit removes every boost current
// - source bit 0 takes system clock from divider output, 1 input
// - feedback divide N is bits 15..12 plus one
// - reference divide M is bits 11..8 plus one
// - polarity 0 lag pumps up, lead pumps down; 1 inverts
// - full power-down switches whole charge pump off
// - quick power-down disables only pump output buffer
// - pump current scale is field value plus one
`ifndef PCPC_CONSTS_SVH
`define PCPC_CONSTS_SVH
// ==========================================================
// control word layout
`define PCPC_WORD_W      40
`define PCPC_WORD_RST    40'h00_0078_0000
`define PCPC_BE_ALL      5'h1f
`define PCPC_RISE_HI     31
`define PCPC_RISE_LO     29
`define PCPC_FALL_HI     28
`define PCPC_FALL_LO     26
`define PCPC_LD_EN       25
`define PCPC_LD_MODE     24
`define PCPC_RF_PD       23
`define PCPC_RF_RAT_HI   22
`define PCPC_RF_RAT_LO   21
`define PCPC_DRV_PD      20
`define PCPC_DRV_SEL_HI  19
`define PCPC_DRV_SEL_LO  18
`define PCPC_BOOST_DIS   17
`define PCPC_SYS_SRC     16
`define PCPC_N_HI        15
`define PCPC_N_LO        12
`define PCPC_M_HI        11
`define PCPC_M_LO        8
`define PCPC_CP_POL      5
`define PCPC_CP_FULL_PD  4
`define PCPC_CP_QUICK_PD 3
`define PCPC_CP_SCL_HI   2
`define PCPC_CP_SCL_LO   0
// ==========================================================
// boost weights, 50 uA units
`define PCPC_BW          9
`define PCPC_RISE_DEF    9'h098
`define PCPC_RISE_W2     9'h098
`define PCPC_RISE_W1     9'h04c
`define PCPC_RISE_W0     9'h026
`define PCPC_FALL_DEF    9'h051
`define PCPC_FALL_W2     9'h06c
`define PCPC_FALL_W1     9'h036
`define PCPC_FALL_W0     9'h01b
// ==========================================================
// lock detect window in CLK cycles, lock count in phase compares
`define PCPC_LOCK_WIN    6'h02
`define PCPC_LOCK_CNT    5'h10
`endif

// ### verilog/pcpc_pkg.sv
// Purpose: types for the clock path control word logic
// Assumes: nothing
// Notes: none
package pcpc_pkg;
  // ==========================================================
  // phase detector state
  typedef enum logic [1:0] {
    PCPC_PFD_IDLE = 2'b00,
    PCPC_PFD_UP   = 2'b01,
    PCPC_PFD_DN   = 2'b10
  } pcpc_pfd_t;
  // ==========================================================
  // driver source codes
  typedef enum logic [1:0] {
    PCPC_DRV_NONE = 2'b00,
    PCPC_DRV_FB   = 2'b01,
    PCPC_DRV_DOUT = 2'b10,
    PCPC_DRV_DIN  = 2'b11
  } pcpc_drv_t;
endpackage

// ### verilog/pcpc_div.sv
// Purpose: programmable edge divider
// Assumes: in_rise is a one-cycle pulse per input rising edge
// Notes: ratio reloads at wrap and while disabled
`timescale 1ns/1ns
module pcpc_div #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         en,
  input  wire logic         in_level,
  input  wire logic         in_rise,
  input  wire logic [W-1:0] ratio,
  output logic              out_tick,
  output logic              out_level
);
  logic [W-1:0] cnt_reg, cnt_next;
  logic [W-1:0] rat_reg, rat_next;
  logic         tick_reg, tick_next;
  logic         lvl_reg, lvl_next;
  logic [W:0]   half;

  // ==========================================================
  // counter
  always_comb begin
    cnt_next  = cnt_reg;
    rat_next  = rat_reg;
    tick_next = 1'b0;
    half      = ({1'b0, rat_reg} + {{W{1'b0}}, 1'b1}) >> 1;
    if (!en) begin
      cnt_next = '0;
      rat_next = ratio;
    end else if (in_rise) begin
      if (cnt_reg == rat_reg - {{(W-1){1'b0}}, 1'b1}) begin
        cnt_next  = '0;
        rat_next  = ratio;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
    end
    if (!en) begin
      lvl_next = 1'b0;
    end else if (rat_reg == {{(W-1){1'b0}}, 1'b1}) begin
      lvl_next = in_level;
    end else begin
      lvl_next = ({1'b0, cnt_next} < half);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg  <= '0;
      rat_reg  <= {{(W-1){1'b0}}, 1'b1};
      tick_reg <= 1'b0;
      lvl_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      rat_reg  <= rat_next;
      tick_reg <= tick_next;
      lvl_reg  <= lvl_next;
    end
  end

  assign out_tick  = tick_reg;
  assign out_level = lvl_reg;
endmodule

// ### sim/pcpc_loop_model.sv
// Purpose: reference source, feedback loop and rf source model
// Assumes: 100 ns phase step, ref period 400 ns, rf period 80 ns
// Notes: fb_dly sets feedback delay in ns, 60 is aligned with ref
`timescale 1ns/1ns
module pcpc_loop_model (
  // loop controls
  input  wire logic       fb_fast,
  input  wire logic [6:0] fb_dly,
  // clock pins
  output logic            ref_clk,
  output logic            fb_clk,
  output logic            rf_clk
);
  // ==========================================================
  // phase generator
  logic [2:0] ph;
  logic       fb_raw;
  initial begin
    ph = 3'h0;
    forever begin
      #100;
      ph = ph + 3'h1;
    end
  end
  initial begin
    rf_clk = 1'b0;
    forever #40 rf_clk = ~rf_clk;
  end
  // ==========================================================
  // delayed pins, fast feedback runs at twice the ref rate
  assign fb_raw = fb_fast ? ~ph[0] : ~ph[1];
  initial ref_clk = 1'b0;
  initial fb_clk = 1'b0;
  always @(ph) ref_clk <= #60 ~ph[1];
  always @(fb_raw) fb_clk <= #(fb_dly) fb_raw;
endmodule

// ### sim/pll_clock_path_config_tb.sv
// Purpose: self-checking bench for the clock path control logic
// Assumes: loop model drives the clock pins
// Notes: counts taken over 640 cycles after a settle
`timescale 1ns/1ns
`include "pcpc_consts.svh"
module pll_clock_path_config_tb
  import pcpc_pkg::*;
;
  // ==========================================================
  // signals
  logic        clk, nrst, word_wr, word_err, pin_ext, pin, fb_fast;
  logic        rf, fb, refc, ssc, rf_div_on, drv_on, drv_out, p_up, p_dn;
  logic        core_on, pin_o, pin_oe, sync_q, locked;
  logic [4:0]  word_be;
  logic [39:0] word_wdata, word_rdata, w;
  logic [8:0]  rise_b, fall_b;
  logic [3:0]  p_scale;
  logic [6:0]  fb_dly;
  logic [1:0]  errs;
  int          n_mismatch, compares, c_sys, c_drv, c_up, c_dn;
  assign pin = pin_oe ? pin_o : pin_ext;
  pcpc_top pcpc_top_inst (
    .CLK(clk), .NRST(nrst), .WORD_WR(word_wr), .WORD_BE(word_be),
    .WORD_WDATA(word_wdata), .WORD_RDATA(word_rdata), .WORD_ERR(word_err),
    .RF_CLOCK_INPUT(rf), .FEEDBACK_CLOCK_INPUT(fb), .REFERENCE_INPUT(refc),
    .SYNTH_SYSTEM_CLOCK(ssc), .RF_DIV_ON(rf_div_on), .DRIVER_ON(drv_on),
    .DRIVER_OUT(drv_out), .RISE_BOOST(rise_b), .FALL_BOOST(fall_b),
    .PUMP_UP(p_up), .PUMP_DN(p_dn), .PUMP_CORE_ON(core_on), .PUMP_SCALE(p_scale),
    .STATUS_PIN_I(pin), .STATUS_PIN_O(pin_o), .STATUS_PIN_OE(pin_oe),
    .SYNC_IN_Q(sync_q), .LOCKED(locked)
  );
  pcpc_loop_model pcpc_loop_model_inst (
    .fb_fast(fb_fast), .fb_dly(fb_dly), .ref_clk(refc), .fb_clk(fb), .rf_clk(rf)
  );
  // ==========================================================
  // helpers
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp);
    compares++;
    if (got < exp - 1 || got > exp + 1) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [39:0] d, input logic [4:0] be);
    @(posedge clk);
    #1;
    word_wr = 1'b1;
    word_be = be;
    word_wdata = d;
    @(posedge clk);
    #1;
    word_wr = 1'b0;
    errs = {1'b0, word_err};
    @(posedge clk);
    #1;
    errs = errs + {1'b0, word_err};
    @(posedge clk);
    #1;
  endtask
  task automatic meas();
    logic ps, pd;
    c_sys = 0;
    c_drv = 0;
    c_up = 0;
    c_dn = 0;
    repeat (80) @(posedge clk);
    #1;
    ps = ssc;
    pd = drv_out;
    repeat (640) begin
      @(posedge clk);
      #1;
      if (ssc === 1'b1 && ps === 1'b0) c_sys++;
      if (drv_out === 1'b1 && pd === 1'b0) c_drv++;
      if (p_up === 1'b1) c_up++;
      if (p_dn === 1'b1) c_dn++;
      ps = ssc;
      pd = drv_out;
    end
  endtask
  task automatic stop_test();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    repeat (4) @(posedge clk);
    #1;
    chk(word_rdata, `PCPC_WORD_RST);
    chk(drv_on, 1'b0);
    chk(rise_b, `PCPC_RISE_DEF);
    chk(fall_b, `PCPC_FALL_DEF);
    chk(core_on, 1'b1);
    chk(p_scale, 4'h1);
    chk(pin_oe, 1'b0);
    chk(rf_div_on, 1'b1);
    chk(sync_q, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_err();
    w = `PCPC_WORD_RST;
    w[11:8] = 4'h5;
    wr(w, 5'h0f);
    chk(errs, 2'h1);
    chk(word_rdata, `PCPC_WORD_RST);
    wr(w, `PCPC_BE_ALL);
    chk(errs, 2'h0);
    chk(word_rdata, w);
    $display("test err done");
  endtask
  task automatic t_boost();
    logic [8:0] rw [3];
    logic [8:0] fw [3];
    rw = '{`PCPC_RISE_W2, `PCPC_RISE_W1, `PCPC_RISE_W0};
    fw = '{`PCPC_FALL_W2, `PCPC_FALL_W1, `PCPC_FALL_W0};
    for (int i = 0; i < 6; i++) begin
      w = `PCPC_WORD_RST;
      w[31 - i] = 1'b1;
      wr(w, `PCPC_BE_ALL);
      if (i < 3) begin
        chk(rise_b, `PCPC_RISE_DEF + rw[i]);
        chk(fall_b, `PCPC_FALL_DEF);
      end else begin
        chk(rise_b, `PCPC_RISE_DEF);
        chk(fall_b, `PCPC_FALL_DEF + fw[i - 3]);
      end
    end
    w[31:26] = 6'h3f;
    w[`PCPC_BOOST_DIS] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    chk(rise_b, 9'h000);
    chk(fall_b, 9'h000);
    $display("test boost done");
  endtask
  task automatic t_pump();
    for (int i = 0; i < 8; i++) begin
      w = `PCPC_WORD_RST;
      w[2:0] = i[2:0];
      wr(w, `PCPC_BE_ALL);
      chk(p_scale, i + 1);
    end
    w[`PCPC_CP_FULL_PD] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    chk(core_on, 1'b0);
    $display("test pump done");
  endtask
  task automatic t_rf();
    for (int r = 0; r < 4; r++) begin
      w = `PCPC_WORD_RST;
      w[`PCPC_DRV_PD] = 1'b0;
      w[22:21] = r[1:0];
      wr(w, `PCPC_BE_ALL);
      meas();
      near(c_sys, 80 >> r);
      near(c_drv, 80 >> r);
    end
    w[`PCPC_SYS_SRC] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    meas();
    near(c_sys, 80);
    w[`PCPC_SYS_SRC] = 1'b0;
    w[`PCPC_RF_PD] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    meas();
    chk(rf_div_on, 1'b0);
    near(c_sys, 80);
    $display("test rf done");
  endtask
  task automatic t_drv();
    int ex [4];
    ex = '{0, 16, 10, 80};
    for (int s = 0; s < 4; s++) begin
      w = `PCPC_WORD_RST;
      w[`PCPC_DRV_PD] = 1'b0;
      w[19:18] = s[1:0];
      wr(w, `PCPC_BE_ALL);
      meas();
      near(c_drv, ex[s]);
      chk(drv_on, 1'b1);
    end
    w[`PCPC_DRV_PD] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    meas();
    chk(drv_on, 1'b0);
    near(c_drv, 0);
    $display("test driver done");
  endtask
  task automatic t_lock();
    w = `PCPC_WORD_RST;
    w[`PCPC_LD_EN] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    repeat (2000) @(posedge clk);
    #1;
    chk(pin_oe, 1'b1);
    chk(sync_q, 1'b0);
    chk(pin_o, 1'b0);
    chk(locked, 1'b1);
    fb_fast = 1'b1;
    repeat (2000) @(posedge clk);
    #1;
    chk(pin_o, 1'b1);
    fb_fast = 1'b0;
    fb_dly = 7'h6e;
    w[`PCPC_LD_MODE] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    meas();
    chk(pin_o, 1'b1);
    chk(c_up > 0, 1'b1);
    chk(c_dn, 0);
    fb_dly = 7'h0a;
    meas();
    chk(pin_o, 1'b0);
    chk(c_dn > 0, 1'b1);
    chk(c_up, 0);
    w[`PCPC_CP_POL] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    meas();
    chk(c_up > 0, 1'b1);
    chk(c_dn, 0);
    w[`PCPC_CP_QUICK_PD] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    meas();
    chk(c_up + c_dn, 0);
    chk(core_on, 1'b1);
    w[`PCPC_CP_QUICK_PD] = 1'b0;
    w[`PCPC_CP_FULL_PD] = 1'b1;
    wr(w, `PCPC_BE_ALL);
    meas();
    chk(c_up + c_dn, 0);
    chk(locked, 1'b0);
    w[`PCPC_LD_EN] = 1'b0;
    wr(w, `PCPC_BE_ALL);
    chk(pin_oe, 1'b0);
    fb_dly = 7'h3c;
    $display("test lock done");
  endtask
  task automatic t_div();
    fb_fast = 1'b1;
    w = `PCPC_WORD_RST;
    w[15:12] = 4'h3;
    wr(w, `PCPC_BE_ALL);
    meas();
    chk(c_up > c_dn, 1'b1);
    w[15:12] = 4'h0;
    w[11:8] = 4'h3;
    wr(w, `PCPC_BE_ALL);
    meas();
    chk(c_dn > c_up, 1'b1);
    fb_fast = 1'b0;
    $display("test div done");
  endtask
  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    word_wr = 1'b0;
    word_be = 5'h00;
    word_wdata = 40'h0;
    pin_ext = 1'b1;
    fb_fast = 1'b0;
    fb_dly = 7'h3c;
    n_mismatch = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_err();
    t_boost();
    t_pump();
    t_rf();
    t_drv();
    t_lock();
    t_div();
    stop_test();
  end
endmodule
